/* File: inc/cssel_pkg.sv */
/*
  Package of constants and types for the card supply class selector.
  Assumes a single 10 MHz clock domain and an external ATR parser that reports
  per-attempt results as one-cycle pulses.
*/
package cssel_pkg;
  // ****************************************************
  // Class encoding
  // ****************************************************
  localparam int          CSSEL_NCLASS    = 5;
  localparam logic [4:0]  CSSEL_CLS_A     = 5'h01;
  localparam logic [4:0]  CSSEL_CLS_B     = 5'h02;
  localparam logic [4:0]  CSSEL_CLS_C     = 5'h04;
  localparam logic [4:0]  CSSEL_CLS_NONE  = 5'h00;
  localparam logic [1:0]  CSSEL_RETRY_MAX = 2'h3;
  // ****************************************************
  // Default budgets in units of 0.1 mA
  // ****************************************************
  localparam logic [9:0]  CSSEL_BUD_A     = 10'h064;
  localparam logic [9:0]  CSSEL_BUD_B     = 10'h04B;
  localparam logic [9:0]  CSSEL_BUD_C     = 10'h032;
  localparam logic [9:0]  CSSEL_BUD_RST   = 10'h000;

  typedef enum logic [2:0] {
    CSSEL_IDLE, CSSEL_ACT, CSSEL_WAIT, CSSEL_DEACT, CSSEL_READY, CSSEL_REJECT
  } cssel_state_e;
endpackage

/* File: inc/cssel_if.sv */
/*
  Interface carrying the class stepping request between the sequencer and
  its class picker. Assumes both ends share one clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface cssel_if;
  logic [4:0] cur;     // Current one-hot class
  logic [4:0] allowed; // Classes the next pick may use
  logic [4:0] pick;    // Lowest allowed class above or at floor
  logic       up;      // Pick strictly above cur
  modport seq (output cur, output allowed, output up, input pick);
  modport pkr (input cur, input allowed, input up, output pick);
endinterface
`default_nettype wire

/* File: hdl/cssel_pick.sv */
/*
  Class picker: lowest allowed one-hot class, optionally strictly above the
  current class. Assumes the interface is driven by the sequencer.
*/
`timescale 1ns/10ps
`default_nettype none
module cssel_pick
  import cssel_pkg::*;
(
  // Request
  cssel_if.pkr p
);
  // ****************************************************
  // Priority search from the lowest class upward
  // ****************************************************
  always_comb begin
    logic above;
    above  = 1'b0;
    p.pick = CSSEL_CLS_NONE;
    for (int k = 0; k < CSSEL_NCLASS; k++) begin
      if (p.allowed[k] && (above || !p.up) && (p.pick == CSSEL_CLS_NONE)) begin
        p.pick[k] = 1'b1;
      end
      if (p.cur[k]) begin
        above = 1'b1;
      end
    end
  end
endmodule // cssel_pick
`default_nettype wire

/* File: hdl/cssel_top.sv */
/*
  Card supply class selector: steps the supply class during activation,
  reacts to ATR results and records the application power budget.
  Assumes the contact sequencer reports deactivation done/ATR outcome pulses
  and an ATR parser hands over the TAi class bits.
*/
`timescale 1ns/10ps
`default_nettype none
module cssel_top
  import cssel_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  // Control
  input  wire logic        i_start,
  input  wire logic [4:0]  i_term_classes,
  input  wire logic        i_allow_step_up,
  // Contact sequencer
  input  wire logic        i_deact_done,
  // ATR outcome pulses
  input  wire logic        i_atr_none,
  input  wire logic        i_atr_corrupt,
  input  wire logic        i_atr_ok,
  input  wire logic        i_atr_cls_valid,
  input  wire logic [4:0]  i_atr_cls,
  // Application power indication
  input  wire logic        i_pwr_valid,
  input  wire logic        i_pwr_none,
  input  wire logic [9:0]  i_pwr_value,
  // Outputs
  output logic             o_activate,
  output logic             o_deactivate,
  output logic [4:0]       o_class,
  output logic             o_busy,
  output logic             o_ready,
  output logic             o_rejected,
  output logic [9:0]       o_app_budget,
  output logic             o_budget_valid
);
  // ****************************************************
  // State
  // ****************************************************
  // One packed record keeps every piece of state in a single register,
  // so the whole sequencer moves on one edge and resets as one word
  typedef struct packed {
    cssel_state_e st;
    logic [4:0]   cls;
    logic [4:0]   card_cls;
    logic [1:0]   corrupt_cnt;
    logic         stepped;   // Corruption step-up already used
    logic         first;     // Still at first class, or moved on only by a silent-card step
    logic [4:0]   next_cls;  // Class for the coming activation
    logic         act;
    logic         deact;
    logic         rejected;
    logic [9:0]   budget;
    logic         bud_val;
  } cssel_s;

  cssel_s cur_ff;
  cssel_s nxt_cur;
  cssel_if pif ();

  cssel_pick u_pick (
    .p (pif.pkr)
  );

  // Picker request; up when stepping after no ATR or corruption
  always_comb begin
    pif.cur     = cur_ff.cls;
    pif.up      = (cur_ff.cls != CSSEL_CLS_NONE);
    pif.allowed = i_term_classes;
    if (cur_ff.st == CSSEL_WAIT && i_atr_ok && i_atr_cls_valid) begin
      pif.up      = 1'b0;
      pif.allowed = i_term_classes & i_atr_cls;
    end
  end

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_comb begin
    logic [4:0] nxt_up;
    logic [4:0] adj_up;
    // Next higher means the class right above the applied one; a gap in
    // the terminal's classes ends the search instead of skipping a class,
    // which keeps both the silent-card and the corruption retries honest
    adj_up  = {cur_ff.cls[3:0], 1'b0};
    nxt_up  = (pif.pick == adj_up) ? pif.pick : CSSEL_CLS_NONE;
    nxt_cur = cur_ff;
    nxt_cur.act   = 1'b0;
    nxt_cur.deact = 1'b0;
    unique case (cur_ff.st)
      CSSEL_IDLE: begin
        // A start clears every leftover of the previous card except card_cls
        if (i_start) begin
          nxt_cur.cls         = CSSEL_CLS_NONE;
          nxt_cur.corrupt_cnt = 2'h0;
          nxt_cur.stepped     = 1'b0;
          nxt_cur.first       = 1'b1;
          nxt_cur.rejected    = 1'b0;
          nxt_cur.bud_val     = 1'b0;
          nxt_cur.budget      = CSSEL_BUD_RST;
          nxt_cur.next_cls    = CSSEL_CLS_NONE;
          nxt_cur.st          = CSSEL_ACT;
        end
      end
      CSSEL_ACT: begin
        // Cls none means first try: picker gives lowest terminal class
        if (cur_ff.cls == CSSEL_CLS_NONE) begin
          nxt_cur.cls = pif.pick;
        end else begin
          nxt_cur.cls = cur_ff.next_cls;
        end
        if ((cur_ff.cls == CSSEL_CLS_NONE ? pif.pick : cur_ff.next_cls) == CSSEL_CLS_NONE) begin
          nxt_cur.st = CSSEL_REJECT;
        end else begin
          nxt_cur.act = 1'b1;
          nxt_cur.st  = CSSEL_WAIT;
        end
      end
      CSSEL_WAIT: begin
        // Outcome pulses are exclusive; silence wins if a card misbehaves
        if (i_atr_none) begin
          // No answer: the adjacent higher class, if the terminal has it
          nxt_cur.next_cls = nxt_up;
          nxt_cur.corrupt_cnt = 2'h0;
          nxt_cur.deact = 1'b1;
          nxt_cur.st    = (nxt_up == CSSEL_CLS_NONE) ? CSSEL_REJECT : CSSEL_DEACT;
        end else if (i_atr_corrupt) begin
          // Repeats stay at the applied class, so the class check
          // still runs when one of them finally brings a clean answer
          nxt_cur.deact = 1'b1;
          if (cur_ff.corrupt_cnt + 2'h1 < CSSEL_RETRY_MAX) begin
            nxt_cur.corrupt_cnt = cur_ff.corrupt_cnt + 2'h1;
            nxt_cur.next_cls    = cur_ff.cls;
            nxt_cur.st          = CSSEL_DEACT;
          end else if (i_allow_step_up && !cur_ff.stepped && nxt_up != CSSEL_CLS_NONE) begin
            // Only the adjacent class survives the filter above
            nxt_cur.corrupt_cnt = 2'h0;
            nxt_cur.first       = 1'b0;
            nxt_cur.stepped     = 1'b1;
            nxt_cur.next_cls    = nxt_up;
            nxt_cur.st          = CSSEL_DEACT;
          end else begin
            nxt_cur.st = CSSEL_REJECT;
          end
        end else if (i_atr_ok) begin
          nxt_cur.corrupt_cnt = 2'h0;
          // Parse class bits before keeping the class
          // While first is set, class bits that leave out the applied class force a new
          // activation at the lowest class both support, or a reject if none; later answers are taken as they come
          if (cur_ff.first && i_atr_cls_valid &&
              ((i_atr_cls & cur_ff.cls) == CSSEL_CLS_NONE)) begin
            nxt_cur.card_cls = i_atr_cls;
            nxt_cur.first    = 1'b0;
            nxt_cur.deact    = 1'b1;
            nxt_cur.next_cls = pif.pick;
            nxt_cur.st       = (pif.pick == CSSEL_CLS_NONE) ? CSSEL_REJECT : CSSEL_DEACT;
          end else begin
            nxt_cur.card_cls = i_atr_cls_valid ? i_atr_cls : cur_ff.cls;
            nxt_cur.st       = CSSEL_READY;
          end
        end
      end
      CSSEL_DEACT: begin
        // Nothing else runs until switching is finished
        if (i_deact_done) begin
          nxt_cur.st = CSSEL_ACT;
        end
      end
      CSSEL_READY: begin
        // A figure from the card wins over the default of the class
        if (i_pwr_valid) begin
          nxt_cur.budget  = i_pwr_value;
          nxt_cur.bud_val = 1'b1;
        end else if (i_pwr_none) begin
          nxt_cur.bud_val = 1'b1;
          unique case (cur_ff.cls)
            CSSEL_CLS_A: nxt_cur.budget = CSSEL_BUD_A;
            CSSEL_CLS_B: nxt_cur.budget = CSSEL_BUD_B;
            CSSEL_CLS_C: nxt_cur.budget = CSSEL_BUD_C;
            default:     nxt_cur.budget = CSSEL_BUD_RST;
          endcase
        end
        if (i_start) begin
          nxt_cur.st = CSSEL_IDLE;
        end
      end
      CSSEL_REJECT: begin
        // Sticky until the next sequence is started
        nxt_cur.rejected = 1'b1;
        if (i_start) begin
          nxt_cur.st = CSSEL_IDLE;
        end
      end
      default: nxt_cur.st = CSSEL_IDLE;
    endcase
  end

  // ****************************************************
  // Registers
  // ****************************************************
  // Reset loads constants only; no input reaches the reset branch
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cur_ff <= '{st: CSSEL_IDLE, cls: CSSEL_CLS_NONE, card_cls: CSSEL_CLS_NONE,
                  corrupt_cnt: 2'h0, stepped: 1'b0, first: 1'b0, next_cls: CSSEL_CLS_NONE,
                  act: 1'b0, deact: 1'b0, rejected: 1'b0, budget: CSSEL_BUD_RST, bud_val: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs straight from state
  // Busy covers ACT, WAIT and DEACT; the deactivate pulse into REJECT falls outside it
  assign o_activate     = cur_ff.act;
  assign o_deactivate   = cur_ff.deact;
  assign o_class        = cur_ff.cls;
  assign o_busy         = (cur_ff.st != CSSEL_IDLE) && (cur_ff.st != CSSEL_READY) && (cur_ff.st != CSSEL_REJECT);
  assign o_ready        = (cur_ff.st == CSSEL_READY);
  assign o_rejected     = cur_ff.rejected;
  assign o_app_budget   = cur_ff.budget;
  assign o_budget_valid = cur_ff.bud_val;
endmodule // cssel_top
`default_nettype wire

/* File: bench/cssel_chk.sv */
/* Assertions on the class selector top ports.
   Assumes one clock domain; bound into cssel_top below. */
`timescale 1ns/10ps
`default_nettype none
module cssel_chk
  import cssel_pkg::*;
(
  // Clock, reset, control
  input wire logic       i_mclk,
  input wire logic       i_resetn,
  input wire logic       i_start,
  input wire logic [4:0] i_term_classes,
  input wire logic       i_allow_step_up,
  // Card results
  input wire logic       i_atr_none,
  input wire logic       i_atr_corrupt,
  input wire logic       i_atr_ok,
  input wire logic       i_atr_cls_valid,
  input wire logic [4:0] i_atr_cls,
  input wire logic       i_pwr_valid,
  input wire logic       i_pwr_none,
  input wire logic [9:0] i_pwr_value,
  // Selector outputs
  input wire logic       o_activate,
  input wire logic       o_deactivate,
  input wire logic [4:0] o_class,
  input wire logic       o_busy,
  input wire logic       o_ready,
  input wire logic       o_rejected,
  input wire logic [9:0] o_app_budget,
  input wire logic       o_budget_valid
);
  logic [4:0] last_ff;
  logic [1:0] crpt_ff;
  logic       none_ff;
  logic [9:0] bud;
  // Attempt history; start clears none_ff and crpt_ff, not last_ff, so a new run is judged alone
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      last_ff <= 5'h00;
      crpt_ff <= 2'h0;
      none_ff <= 1'b0;
    end else begin
      if (o_activate) last_ff <= o_class;
      none_ff <= i_atr_none | (none_ff & ~o_activate & ~i_start);
      if (i_atr_corrupt) crpt_ff <= crpt_ff + 2'h1;
      else if (i_atr_none | i_atr_ok | i_start | (o_activate & crpt_ff == 2'h3)) crpt_ff <= 2'h0;
    end
  end
  // Default budget of the applied class
  assign bud = o_class[0] ? CSSEL_BUD_A : (o_class[1] ? CSSEL_BUD_B : (o_class[2] ? CSSEL_BUD_C : CSSEL_BUD_RST));
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  property p_first;
    i_start && !o_busy && !o_ready && !o_rejected && i_term_classes != 5'h00
      |-> ##[1:3] (o_activate && o_class == (i_term_classes & (~i_term_classes + 5'h01)));
  endproperty
  a_first: assert property (p_first) else $error("first class not lowest");
  property p_none; i_atr_none && o_busy |=> o_deactivate; endproperty
  a_none: assert property (p_none) else $error("no deactivate after silence");
  property p_up; o_activate && none_ff |-> o_class == {last_ff[3:0], 1'b0}; endproperty
  a_up: assert property (p_up) else $error("retry not next class");
  property p_unsup;
    i_atr_ok && i_atr_cls_valid && (i_atr_cls & o_class) == 5'h00
      && o_class == (i_term_classes & (~i_term_classes + 5'h01)) |=> o_deactivate;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported class kept");
  property p_ok;
    i_atr_ok && o_busy && !(i_atr_cls_valid && (i_atr_cls & o_class) == 5'h00) |=> o_ready;
  endproperty
  a_ok: assert property (p_ok) else $error("good answer not accepted");
  property p_same; o_activate && crpt_ff != 2'h0 && crpt_ff != 2'h3 |-> o_class == last_ff; endproperty
  a_same: assert property (p_same) else $error("repeat changed class");
  property p_step; o_activate && crpt_ff == 2'h3 |-> o_class == {last_ff[3:0], 1'b0}; endproperty
  a_step: assert property (p_step) else $error("step not next class");
  property p_rej;
    i_atr_corrupt && crpt_ff == 2'h2 && !i_allow_step_up |-> ##[1:3] o_rejected;
  endproperty
  a_rej: assert property (p_rej) else $error("card not rejected");
  property p_dflt; o_ready && i_pwr_none |=> o_budget_valid && o_app_budget == bud; endproperty
  a_dflt: assert property (p_dflt) else $error("default budget wrong");
  property p_pwr; o_ready && i_pwr_valid |=> o_budget_valid && o_app_budget == $past(i_pwr_value); endproperty
  a_pwr: assert property (p_pwr) else $error("card budget wrong");
  c_rej: cover property ($rose(o_rejected));
  c_step: cover property (o_activate && crpt_ff == 2'h3);
  c_dflt: cover property (o_ready && i_pwr_none);
endmodule // cssel_chk
bind cssel_top cssel_chk u_chk (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_start(i_start),
  .i_term_classes(i_term_classes), .i_allow_step_up(i_allow_step_up), .i_atr_none(i_atr_none),
  .i_atr_corrupt(i_atr_corrupt), .i_atr_ok(i_atr_ok), .i_atr_cls_valid(i_atr_cls_valid),
  .i_atr_cls(i_atr_cls), .i_pwr_valid(i_pwr_valid), .i_pwr_none(i_pwr_none), .i_pwr_value(i_pwr_value),
  .o_activate(o_activate), .o_deactivate(o_deactivate), .o_class(o_class), .o_busy(o_busy),
  .o_ready(o_ready), .o_rejected(o_rejected), .o_app_budget(o_app_budget), .o_budget_valid(o_budget_valid));
`default_nettype wire

/* File: bench/cssel_card.sv */
/* Card model: answers each activation per class, each deactivation with done.
   Assumes the selector keeps its class stable while waiting. */
`timescale 1ns/10ps
`default_nettype none
module cssel_card (
  // Clock, reset, selector
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_activate,
  input  wire logic       i_deactivate,
  input  wire logic [4:0] i_class,
  // Setup: outcome per class A..C (0 none,1 corrupt,2 ok+bits,3 ok), bits, delay
  input  wire logic [5:0] i_mode,
  input  wire logic [4:0] i_card_cls,
  input  wire logic [2:0] i_delay,
  // Answers
  output logic            o_atr_none,
  output logic            o_atr_corrupt,
  output logic            o_atr_ok,
  output logic            o_cls_valid,
  output logic [4:0]      o_atr_cls,
  output logic            o_deact_done
);
  logic [1:0] job_ff;
  logic [2:0] wait_ff;
  logic [1:0] md;
  assign md = i_class[0] ? i_mode[1:0] : (i_class[1] ? i_mode[3:2] : i_mode[5:4]);
  // One job at a time; the class bits churn when not valid
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      job_ff <= 2'h0;
      wait_ff <= 3'h0;
      {o_atr_none, o_atr_corrupt, o_atr_ok, o_cls_valid, o_deact_done, o_atr_cls} <= 10'h000;
    end else begin
      {o_atr_none, o_atr_corrupt, o_atr_ok, o_cls_valid, o_deact_done} <= 5'h00;
      o_atr_cls <= ~o_atr_cls;
      if (i_activate | i_deactivate) begin
        job_ff  <= i_activate ? 2'h1 : 2'h2;
        wait_ff <= i_delay;
      end else if (wait_ff != 3'h0) wait_ff <= wait_ff - 3'h1;
      else if (job_ff == 2'h1) begin
        job_ff        <= 2'h0;
        o_atr_none    <= (md == 2'h0);
        o_atr_corrupt <= (md == 2'h1);
        o_atr_ok      <= md[1];
        o_cls_valid   <= (md == 2'h2);
        if (md == 2'h2) o_atr_cls <= i_card_cls;
      end else if (job_ff == 2'h2) begin
        job_ff       <= 2'h0;
        o_deact_done <= 1'b1;
      end
    end
  end
endmodule // cssel_card
`default_nettype wire

/* File: bench/cssel_tb_top.sv */
/* Self-checking bench for the class selector with a card model.
   Assumes the package constants; stimulus 1 ns after each rising edge. */
`timescale 1ns/10ps
`default_nettype none
module cssel_tb_top;
  import cssel_pkg::*;
  logic       clk, rstn, start, step, pv, pn, act, deact, busy, ready, rej, bv, an, ac, ao, av, dd;
  logic [4:0] term, ccls, cls, acls;
  logic [5:0] mode;
  logic [2:0] dly;
  logic [9:0] pval, bud;
  int         n_fail, check_count, acts;
  always #50 clk = ~clk;
  always @(posedge clk) if (act) acts++;
  cssel_top dut (.i_mclk(clk), .i_resetn(rstn), .i_start(start), .i_term_classes(term),
    .i_allow_step_up(step), .i_deact_done(dd), .i_atr_none(an), .i_atr_corrupt(ac), .i_atr_ok(ao),
    .i_atr_cls_valid(av), .i_atr_cls(acls), .i_pwr_valid(pv), .i_pwr_none(pn), .i_pwr_value(pval),
    .o_activate(act), .o_deactivate(deact), .o_class(cls), .o_busy(busy), .o_ready(ready),
    .o_rejected(rej), .o_app_budget(bud), .o_budget_valid(bv));
  cssel_card card (.i_mclk(clk), .i_resetn(rstn), .i_activate(act), .i_deactivate(deact), .i_class(cls),
    .i_mode(mode), .i_card_cls(ccls), .i_delay(dly), .o_atr_none(an), .o_atr_corrupt(ac),
    .o_atr_ok(ao), .o_cls_valid(av), .o_atr_cls(acls), .o_deact_done(dd));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic pulse();
    @(posedge clk);
    #1 start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
  endtask
  // One whole activation sequence, bounded wait for the end state
  task automatic run(input logic [4:0] tc, input logic [5:0] md, input logic [4:0] cc, input logic st,
                     input logic [4:0] ec, input logic er, input logic [3:0] ea);
    int k;
    if (ready | rej) pulse();
    {term, mode, ccls, step, acts} = {tc, md, cc, st, 32'd0};
    pulse();
    chk(10'(busy), 10'h001);
    for (k = 0; k < 400 && !(ready | rej); k++) @(posedge clk) #1;
    if (k == 400) begin
      n_fail++;
      print_verdict();
    end
    chk(10'(rej), 10'(er));
    if (!er) chk(10'(cls), 10'(ec));
    chk(10'(acts), 10'(ea));
    chk(10'(busy), 10'h000);
  endtask
  task automatic pwr(input logic v, input logic [9:0] val, input logic [9:0] e);
    {pv, pn, pval} = {v, !v, val};
    @(posedge clk) #1 {pv, pn, pval} = {2'b00, ~val};
    @(posedge clk) #1;
    chk(10'(bv), 10'h001);
    chk(bud, e);
  endtask
  task automatic t_lowest();
    logic [9:0] tb_bud [3] = '{CSSEL_BUD_A, CSSEL_BUD_B, CSSEL_BUD_C};
    for (int i = 0; i < 3; i++) begin
      dly = 3'(i);
      run(5'h07 & (5'h1F << i), 6'h3F, 5'h07, 1'b0, 5'h01 << i, 1'b0, 4'h1);
      pwr(1'b0, 10'h155, tb_bud[i]);
    end
  endtask
  task automatic t_noatr();
    dly = 3'h5;
    run(5'h07, 6'h28, 5'h06, 1'b0, 5'h02, 1'b0, 4'h2);
    pwr(1'b1, 10'h2A5, 10'h2A5);
  endtask
  task automatic t_unsup();
    run(5'h07, 6'h2A, 5'h06, 1'b0, 5'h02, 1'b0, 4'h2);
  endtask
  task automatic t_crpt();
    run(5'h07, 6'h29, 5'h03, 1'b0, 5'h00, 1'b1, 4'h3);
    run(5'h07, 6'h29, 5'h03, 1'b1, 5'h02, 1'b0, 4'h4);
  endtask
  task automatic t_allnone();
    run(5'h07, 6'h00, 5'h07, 1'b0, 5'h00, 1'b1, 4'h3);
    run(5'h04, 6'h00, 5'h07, 1'b0, 5'h00, 1'b1, 4'h1);
  endtask
  initial begin
    {clk, rstn, start, step, pv, pn, term, ccls, mode, dly, pval} = '0;
    {n_fail, check_count, acts} = '0;
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    chk(10'({cls, ready, rej, act}), 10'h000);
    t_lowest();
    t_noatr();
    t_unsup();
    t_crpt();
    t_allnone();
    print_verdict();
  end
endmodule // cssel_tb_top
`default_nettype wire
